// ---- rtl/adcc_consts.vh ----
// Constants for the converter control block: register offsets, fields,
// reset values and phase lengths.
// Assumes inclusion by bare name from design files under rtl/.
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH

// ----------------------------------------
// Register word offsets
// ----------------------------------------
`define ADCC_OFS_CTRL0 5'h00
`define ADCC_OFS_CTRL1 5'h01
`define ADCC_OFS_STAT 5'h02
`define ADCC_FMT_URJ 2'h1
`define ADCC_FMT_SLJ 2'h2
`define ADCC_FMT_ULJ 2'h3

// ----------------------------------------
// Control field positions and resets
// ----------------------------------------
`define ADCC_C0_PRS 4:0
`define ADCC_C0_STS 6:5
`define ADCC_C0_TEN_BIT_SEL 7
`define ADCC_C0_RESET 16'h0003
`define ADCC_C1_CHAN 3:0
`define ADCC_C1_MULTI_CHANNEL_SEL 4
`define ADCC_C1_EIGHT_CONV_SEL 5
`define ADCC_C1_SCAN 6

// ----------------------------------------
// Phase lengths in converter clocks
// ----------------------------------------
`define ADCC_T_INIT 5'd2
`define ADCC_T_XFER 5'd2
`define ADCC_T_FS0 5'd2
`define ADCC_T_RES8 5'd10
`define ADCC_T_TEN_BIT_SEL 5'd12
`define ADCC_BITS8 4'd8
`define ADCC_BITS10 4'd10

`endif

// ---- rtl/adcc_ctrl.v ----
// Digital control for a 10-bit successive-approximation converter.
// Assumes a comparator output synchronous to clk_sys and single-cycle
// register accesses by the bus interface unit.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.vh"

// Overview of operation
// - Multi-channel groups of four or eight chosen by high select bits.
// - Each conversion runs initial sample, transfer, final sample, resolution.
// - Initial sample and transfer last two converter clocks each.
// - Final sample lasts 2, 4, 8 or 16 converter clocks.
// - Resolution lasts 10 clocks for eight bits, 12 for ten.
// - Switches route sample capacitor, amplifier and array per phase.
// - Resolution starts with the top trial bit set, lower bits clear.
// - Each compare keeps or clears the trial bit, then tries the next.
// - Finished approximation is copied into its result register.
// - Each result register reads at three addresses, one per format.
// - Unsigned right view: data low, bits above zero.
// - Signed left view: top bit inverted, low bits zero.
// - Unsigned left view: data high, low bits zero.
// - Result reads go through the bus interface unit.
// - Converter clock is a modulus prescaler then divide by two.
// - Ten-bit select chooses resolution and aligns results.
// - Control one write starts; any control write aborts and clears flags.
// - Per-register done flags; sequence flag at end or first pass.
module adcc_ctrl (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Bus interface unit access
  input wire bus_sel,
  input wire bus_wr,
  input wire [4:0] bus_addr,
  input wire [15:0] bus_wdata,
  output reg [15:0] bus_rdata,
  // Analog front end
  input wire comp_hi,
  output reg [3:0] mux_chan,
  output reg sw_sample_cap,
  output reg sw_amp_drive,
  output reg sw_direct,
  output reg [9:0] dac_code
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_INIT = 3'd1;
  localparam ST_XFER = 3'd2;
  localparam ST_FINAL = 3'd3;
  localparam ST_RES = 3'd4;
  localparam ST_ARM = 3'd5;

  reg [15:0] ctrl0_r;
  reg [6:0] ctrl1_r;
  reg [2:0] state_r;
  reg [4:0] phase_cnt_r;
  reg [2:0] conv_idx_r;
  reg [9:0] sar_r;
  reg [9:0] trial_r;
  reg [7:0] ccf_r;
  reg scf_r;
  reg [9:0] result_r [0:7];
  reg [4:0] pre_cnt_r;
  reg div2_r;
  reg adc_tick_r;
  integer i;

  wire ctrl_wr = bus_sel & bus_wr;
  wire wr_c0 = ctrl_wr & (bus_addr == `ADCC_OFS_CTRL0);
  wire wr_c1 = ctrl_wr & (bus_addr == `ADCC_OFS_CTRL1);
  wire ten_bit_sel = ctrl0_r[`ADCC_C0_TEN_BIT_SEL];
  wire [2:0] last_idx = ctrl1_r[`ADCC_C1_EIGHT_CONV_SEL] ? 3'd7 : 3'd3;

  // Final sample length from the two-bit code.
  function [4:0] fs_len;
    input [1:0] code;
    begin
      fs_len = `ADCC_T_FS0 << code;
    end
  endfunction

  // Lowest trial bit for the selected resolution.
  function [9:0] last_trial;
    input ten;
    begin
      last_trial = ten ? 10'h001 : 10'h004;
    end
  endfunction

  // Channel for conversion n of the current sequence.
  function [3:0] chan_of;
    input [6:0] c1;
    input [2:0] n;
    begin
      if (!c1[`ADCC_C1_MULTI_CHANNEL_SEL])
        chan_of = c1[`ADCC_C1_CHAN];
      else if (c1[`ADCC_C1_EIGHT_CONV_SEL])
        chan_of = {c1[3], n};
      else
        chan_of = {c1[3:2], n[1:0]};
    end
  endfunction

  // ----------------------------------------
  // Converter clock prescaler
  // ----------------------------------------
  // The tick is a one-cycle enable rather than a derived clock, which keeps
  // the whole block in a single domain.
  // Code zero is reserved; it ticks every second clock, which leaves the
  // comparator too little time to settle.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_r <= 5'd0;
      div2_r <= 1'b0;
      adc_tick_r <= 1'b0;
    end else begin
      adc_tick_r <= 1'b0;
      if (pre_cnt_r >= ctrl0_r[`ADCC_C0_PRS]) begin
        pre_cnt_r <= 5'd0;
        div2_r <= ~div2_r;
        adc_tick_r <= div2_r;
      end else begin
        pre_cnt_r <= pre_cnt_r + 5'd1;
      end
    end
  end

  // ----------------------------------------
  // Control registers and sequencer
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_r <= `ADCC_C0_RESET;
      ctrl1_r <= 7'h00;
      state_r <= ST_IDLE;
      phase_cnt_r <= 5'd0;
      conv_idx_r <= 3'd0;
      sar_r <= 10'h000;
      trial_r <= 10'h000;
      ccf_r <= 8'h00;
      scf_r <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
        result_r[i] <= 10'h000;
    end else if (wr_c0 | wr_c1) begin
      if (wr_c0)
        ctrl0_r <= bus_wdata;
      if (wr_c1)
        ctrl1_r <= bus_wdata[6:0];
      ccf_r <= 8'h00;
      scf_r <= 1'b0;
      conv_idx_r <= 3'd0;
      phase_cnt_r <= 5'd0;
      // Flags clear on every control write, so a same-cycle set is lost.
      // A start waits for the next converter clock so no phase is cut.
      state_r <= wr_c1 ? ST_ARM : ST_IDLE;
    end else if (adc_tick_r) begin
      phase_cnt_r <= phase_cnt_r + 5'd1;
      case (state_r)
        ST_IDLE: begin
          phase_cnt_r <= 5'd0;
        end
        ST_ARM: begin
          phase_cnt_r <= 5'd0;
          state_r <= ST_INIT;
        end
        ST_INIT: begin
          if (phase_cnt_r == `ADCC_T_INIT - 5'd1) begin
            phase_cnt_r <= 5'd0;
            state_r <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (phase_cnt_r == `ADCC_T_XFER - 5'd1) begin
            phase_cnt_r <= 5'd0;
            state_r <= ST_FINAL;
          end
        end
        ST_FINAL: begin
          if (phase_cnt_r == fs_len(ctrl0_r[`ADCC_C0_STS]) - 5'd1) begin
            phase_cnt_r <= 5'd0;
            state_r <= ST_RES;
            sar_r <= 10'h200;
            trial_r <= 10'h200;
          end
        end
        ST_RES: begin
          // The comparator is read one system clock less than a tick after dac_code moved, so it
          // has had several system clocks to settle.
          if (trial_r != 10'h000) begin
            sar_r <= (comp_hi ? sar_r : (sar_r & ~trial_r)) | (trial_r >> 1);
            trial_r <= (trial_r == last_trial(ten_bit_sel)) ? 10'h000 :
                       (trial_r >> 1);
            // Eight-bit work stops at bit 2, so bits 1:0 are never tried.
            if (trial_r == last_trial(ten_bit_sel))
              sar_r <= comp_hi ? sar_r : (sar_r & ~trial_r);
          end
          if (phase_cnt_r == (ten_bit_sel ? `ADCC_T_TEN_BIT_SEL : `ADCC_T_RES8) - 5'd1)
          begin
            phase_cnt_r <= 5'd0;
            result_r[conv_idx_r] <= ten_bit_sel ? sar_r : {2'b00, sar_r[9:2]};
            ccf_r[conv_idx_r] <= 1'b1;
            conv_idx_r <= conv_idx_r + 3'd1;
            state_r <= ST_INIT;
            if (conv_idx_r == last_idx) begin
              conv_idx_r <= 3'd0;
              scf_r <= 1'b1;
              if (!ctrl1_r[`ADCC_C1_SCAN])
                state_r <= ST_IDLE;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Analog switch outputs
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mux_chan <= 4'h0;
      sw_sample_cap <= 1'b0;
      sw_amp_drive <= 1'b0;
      sw_direct <= 1'b0;
      dac_code <= 10'h000;
    end else begin
      // Switches follow the state one clock late, as all outputs are
      // registered.
      mux_chan <= chan_of(ctrl1_r, conv_idx_r);
      sw_sample_cap <= (state_r == ST_INIT);
      sw_amp_drive <= (state_r == ST_XFER);
      sw_direct <= (state_r == ST_FINAL);
      dac_code <= sar_r;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Results are held right-aligned at ten bits; eight-bit results sit in the
  // low bits so each view only shifts.
  // The view follows the current ten_bit_sel, not the one at conversion.
  reg [15:0] rd_nxt;
  reg [9:0] rv;
  reg [9:0] lv;
  always @* begin
    rd_nxt = 16'h0000;
    rv = result_r[bus_addr[2:0]];
    lv = ten_bit_sel ? rv : {rv[7:0], 2'b00};
    case (bus_addr[4:3])
      `ADCC_FMT_URJ: rd_nxt = ten_bit_sel ? {6'h00, rv} : {8'h00, rv[7:0]};
      `ADCC_FMT_SLJ: rd_nxt = {~lv[9], lv[8:0], 6'h00};
      `ADCC_FMT_ULJ: rd_nxt = {lv, 6'h00};
      default: begin
        if (bus_addr == `ADCC_OFS_CTRL0)
          rd_nxt = ctrl0_r;
        else if (bus_addr == `ADCC_OFS_CTRL1)
          rd_nxt = {9'h000, ctrl1_r};
        else if (bus_addr == `ADCC_OFS_STAT)
          rd_nxt = {scf_r, 7'h00, ccf_r};
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      bus_rdata <= 16'h0000;
    else if (bus_sel & ~bus_wr)
      bus_rdata <= rd_nxt;
  end

endmodule
`default_nettype wire

// ---- verif/adcc_ctrl_properties.sv ----
// Checker for the converter control block, on its ports only.
// Assumes timing fields change only while the converter is idle.
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_properties (
  // Clock, reset and bus
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic bus_sel,
  input wire logic bus_wr,
  input wire logic [4:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  // Front end
  input wire logic sw_sample_cap,
  input wire logic sw_amp_drive,
  input wire logic sw_direct,
  input wire logic [9:0] dac_code
);
  logic [15:0] c0_r;
  logic [11:0] run_r;
  logic [2:0] sw_q;
  logic res_r;
  wire [2:0] sw = {sw_sample_cap, sw_amp_drive, sw_direct};
  wire rd_c = bus_sel && !bus_wr;
  wire wr_c = bus_sel && bus_wr && bus_addr < 5'h02;
  wire [11:0] tick = {6'h00, c0_r[4:0], 1'b0} + 12'h002;
  // Phase lengths are counted in system clocks, so a stuck count shows.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      c0_r <= 16'h0003;
      run_r <= 12'h000;
      sw_q <= 3'h0;
      res_r <= 1'b0;
    end else begin
      sw_q <= sw;
      run_r <= (sw != sw_q) ? 12'h001 : run_r + 12'h001;
      res_r <= !wr_c && !sw[2] && (res_r || (sw_q[0] && !sw[0]));
      if (bus_sel && bus_wr && bus_addr == 5'h00)
        c0_r <= bus_wdata;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_leave_init;
    sw_sample_cap ##1 !sw_sample_cap;
  endsequence
  sequence s_ctl_stat;
    wr_c ##2 (rd_c && bus_addr == 5'h02);
  endsequence
  chk_one_switch: assert property ($onehot0(sw))
    else $error("switches overlap");
  chk_phase_next: assert property (s_leave_init |-> sw_amp_drive)
    else $error("no transfer after sample");
  chk_init_len: assert property (
    sw_q[2] && sw[1] |-> run_r == tick * 2) else $error("init length");
  chk_xfer_len: assert property (
    sw_q[1] && sw[0] |-> run_r == tick * 2) else $error("transfer length");
  chk_final_len: assert property (
    sw_q[0] && !sw[0] |-> run_r == (tick << c0_r[6:5]) * 2)
    else $error("final sample length");
  chk_res_len: assert property (
    $rose(sw_sample_cap) && res_r |-> run_r == tick * (c0_r[7] ? 12 : 10))
    else $error("resolution length");
  chk_trial_msb: assert property (
    $fell(sw_direct) |-> ##[0:2] dac_code == 10'h200)
    else $error("first trial wrong");
  chk_right_high: assert property (
    rd_c && bus_addr[4:3] == 2'b01 |=> bus_rdata[15:10] == 6'h00)
    else $error("right view high bits");
  chk_left_low: assert property (
    rd_c && bus_addr[4] |=> bus_rdata[5:0] == 6'h00)
    else $error("left view low bits");
  chk_abort_clear: assert property (
    s_ctl_stat |=> bus_rdata == 16'h0000) else $error("flags kept");
endmodule
bind adcc_ctrl adcc_ctrl_properties u_props (.clk_sys, .rst_n, .bus_sel,
  .bus_wr, .bus_addr, .bus_wdata, .bus_rdata, .sw_sample_cap,
  .sw_amp_drive, .sw_direct, .dac_code);
`default_nettype wire

// ---- verif/adcc_comp_model.sv ----
// Comparator standing in for the analog front end.
// Assumes the bench holds the input level through a sequence.
`timescale 1ns/1ps
`default_nettype none
module adcc_comp_model (
  // Level and trial
  input wire logic [9:0] level,
  input wire logic [9:0] dac_code,
  // Decision
  output logic comp_hi
);
  assign comp_hi = level >= dac_code;
endmodule
`default_nettype wire

// ---- verif/test_adcc_ctrl.sv ----
// Self-checking bench for the converter control block.
// Assumes the comparator model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_adcc_ctrl;
  logic clk_sys, rst_n, bus_sel, bus_wr, comp_hi;
  logic sw_sample_cap, sw_amp_drive, sw_direct;
  logic [4:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata, rd, c1, lj;
  logic [9:0] dac_code, level;
  logic [3:0] mux_chan, ec;
  logic [3:0] chans [16];
  int fail_count, checks_done, idx, n;
  // Rows: ctrl0, ctrl1, held level, expected status.
  logic [15:0] rows [5][4] = '{
    '{16'h0003, 16'h0005, 16'h02A7, 16'h800F},
    '{16'h00A3, 16'h0016, 16'h0155, 16'h800F},
    '{16'h0043, 16'h003B, 16'h03FF, 16'h80FF},
    '{16'h00E3, 16'h0021, 16'h0000, 16'h80FF},
    '{16'h0003, 16'h0054, 16'h0201, 16'h800F}};
  adcc_ctrl DUT (.clk_sys, .rst_n, .bus_sel, .bus_wr, .bus_addr, .bus_wdata,
    .bus_rdata, .comp_hi, .mux_chan, .sw_sample_cap, .sw_amp_drive,
    .sw_direct, .dac_code);
  adcc_comp_model u_comp (.level, .dac_code, .comp_hi);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // The channel is taken as sampling ends, when mux_chan has settled.
  always @(negedge sw_sample_cap) begin
    if (idx < 16)
      chans[idx] = mux_chan;
    idx++;
  end
  task automatic acc(input logic w, input logic [4:0] a,
    input logic [15:0] d);
    bus_sel <= 1'b1;
    bus_wr <= w;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_sel <= 1'b0;
    @(posedge clk_sys);
    rd = bus_rdata;
  endtask
  task automatic cmp(input string s, input logic [15:0] e,
    input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  // Aborts land in resolution, where no phase edge is cut short.
  task automatic wait_res;
    for (n = 0; n < 3000 && sw_direct !== 1'b1; n++)
      @(posedge clk_sys);
    if (n == 3000)
      fail_count++;
    for (n = 0; n < 3000 && sw_direct !== 1'b0; n++)
      @(posedge clk_sys);
    if (n == 3000)
      fail_count++;
    repeat (20) @(posedge clk_sys);
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1500000;
    fail_count++;
    end_of_test();
  end
  initial begin
    {bus_sel, bus_wr, bus_addr, bus_wdata, level} <= 33'h0;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    acc(1'b0, 5'h00, 16'h0000);
    cmp("ctrl0", 16'h0003, rd);
    acc(1'b0, 5'h04, 16'h0000);
    cmp("unmapped", 16'h0000, rd);
    foreach (rows[r]) begin
      c1 = rows[r][1];
      level <= rows[r][2][9:0];
      acc(1'b1, 5'h00, rows[r][0]);
      idx = 0;
      acc(1'b1, 5'h01, c1);
      rd = 16'h0000;
      for (n = 0; n < 4000 && rd[15] !== 1'b1; n++)
        acc(1'b0, 5'h02, 16'h0000);
      cmp("status", rows[r][3], rd);
      for (int k = 0; k < (c1[5] ? 8 : 4); k++) begin
        lj = rows[r][0][7] ? {level, 6'h00} : {level[9:2], 8'h00};
        ec = !c1[4] ? c1[3:0] : c1[5] ? {c1[3], 3'(k)} : {c1[3:2], 2'(k)};
        cmp("chan", {12'h000, ec}, {12'h000, chans[k]});
        acc(1'b0, 5'(8 + k), 16'h0000);
        cmp("right", rows[r][0][7] ? lj >> 6 : lj >> 8, rd);
        acc(1'b0, 5'(16 + k), 16'h0000);
        cmp("signed", lj ^ 16'h8000, rd);
        acc(1'b0, 5'(24 + k), 16'h0000);
        cmp("left", lj, rd);
      end
    end
    acc(1'b1, 5'h08, 16'hFFFF);
    acc(1'b0, 5'h08, 16'h0000);
    cmp("readonly", 16'h0080, rd);
    wait_res();
    acc(1'b1, 5'h01, 16'h0005);
    wait_res();
    acc(1'b1, 5'h00, 16'h0003);
    acc(1'b0, 5'h02, 16'h0000);
    cmp("abort", 16'h0000, rd);
    idx = 0;
    repeat (300) @(posedge clk_sys);
    cmp("idle", 16'h0000, 16'(idx));
    // A reset in mid-conversion must leave the block idle at defaults.
    acc(1'b1, 5'h01, 16'h0025);
    wait_res();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    acc(1'b0, 5'h02, 16'h0000);
    cmp("reset status", 16'h0000, rd);
    acc(1'b0, 5'h00, 16'h0000);
    cmp("reset ctrl0", 16'h0003, rd);
    lj = {3'h0, sw_sample_cap, sw_amp_drive, sw_direct, dac_code};
    cmp("reset outputs", 16'h0000, lj);
    end_of_test();
  end
endmodule
`default_nettype wire
